/* File: verilog/smrc_top.sv */
`timescale 1ns/1ps
`include "smrc_consts.svh"

module smrc_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    input  wire logic              POR_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic                   PREADY,
    output logic [31:0]            PRDATA,
    output logic                   PSLVERR,
    input  wire logic              CMP_BELOW_FALL,
    input  wire logic              CMP_ABOVE_RISE,
    input  wire logic              STOP_MODE,
    input  wire logic              WAIT_MODE,
    output logic                   CMP_POWER_DOWN,
    output logic                   CMP_LEVEL_HIGH,
    output logic                   RESET_REQ,
    output logic                   RST_PIN_OUT,
    output logic                   RST_PIN_OE,
    output logic                   IRQ
);

    localparam int SETTLE_CYC =
        (`SMRC_SETTLE_NS + `SMRC_CLK_PERIOD_NS - 1) / `SMRC_CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

    // Refuse address widths that cannot reach the register words
    if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr_w
        $error("smrc_top: ADDR_W must be 16..32");
    end

    // A settle count of zero would trust the comparator mid-swing
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("smrc_top: settle count must be at least one");
    end

    // Address decode, shared by read and write paths
    function automatic smrc_pkg::smrc_reg_t decode(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        logic [15:0] lo;
        wide   = 32'(a);
        lo     = wide[15:0];
        decode = smrc_pkg::SMRC_REG_NONE;
        // Upper address bits must be zero; widening avoids a reversed slice
        if (wide[31:16] == 16'h0000) begin
            unique case (lo)
                `SMRC_OFS_CONFIG: decode = smrc_pkg::SMRC_REG_CONFIG;
                `SMRC_OFS_STATUS: decode = smrc_pkg::SMRC_REG_STATUS;
                `SMRC_OFS_EVENT:  decode = smrc_pkg::SMRC_REG_EVENT;
                `SMRC_OFS_MASK:   decode = smrc_pkg::SMRC_REG_MASK;
                default:          decode = smrc_pkg::SMRC_REG_NONE;
            endcase
        end
    endfunction

    logic [`SMRC_CFG_WIDTH-1:0] cfg_q;
    logic                       lvl_sel_q;
    logic                       flag_q;
    logic                       trip_q;
    logic [`SMRC_EVT_WIDTH-1:0] evt_q;
    logic [`SMRC_EVT_WIDTH-1:0] mask_q;
    logic [SETTLE_W-1:0]        settle_q;
    logic                       pready_q;
    logic [31:0]                prdata_q;
    logic                       pslverr_q;
    logic                       irq_q;
    logic                       pd_q;
    logic                       rst_out_q;
    logic [1:0]                 sync1_q;
    logic [1:0]                 sync2_q;

    smrc_pkg::smrc_reg_t sel_reg;
    logic                apb_fire;
    logic                wr_cfg;
    logic                rd_evt;
    logic                active;
    logic                below_s;
    logic                above_s;
    logic                settled;
    logic                raise_lvl;
    logic                trip_set;
    logic                low_set;
    logic [`SMRC_EVT_WIDTH-1:0] evt_hit;

    // Comparator inputs arrive asynchronously; two flops each
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge NRST) begin
                if (!NRST) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= (gi == 0) ? CMP_BELOW_FALL : CMP_ABOVE_RISE;
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Only the second stage is read by the logic
    assign below_s = sync2_q[0];
    assign above_s = sync2_q[1];

    // APB request decode; write and read-clear act only at the access edge
    assign sel_reg  = decode(PADDR);
    assign apb_fire = PSEL && PENABLE && pready_q;
    assign wr_cfg   = apb_fire && PWRITE && (sel_reg == smrc_pkg::SMRC_REG_CONFIG);
    assign rd_evt   = apb_fire && !PWRITE && (sel_reg == smrc_pkg::SMRC_REG_EVENT);

    // Active in run and wait mode unless power-disable is set; stop mode also needs stop-enable.
    // WAIT_MODE is deliberately not gated: the monitor keeps running there,
    // so a low supply can still pull the part out of wait by reset.
    assign active = !cfg_q[`SMRC_CFG_PWR_DIS]
                    && (!STOP_MODE || cfg_q[`SMRC_CFG_STOP_EN]);

    // Comparator trust window and the level-raise strobe
    assign settled   = (settle_q == '0);
    assign raise_lvl = wr_cfg && PWDATA[`SMRC_CFG_LVL_SEL] && !lvl_sel_q;

    // Reset request: low supply, or level raised to the higher pair.
    // The new pair is not trusted at once, so a raise trips first while active with reset enabled
    assign trip_set = active && !cfg_q[`SMRC_CFG_RST_DIS]
                      && ((settled && below_s) || raise_lvl);
    assign low_set  = active && settled && below_s && !flag_q;

    // All four configuration bits, level select copy included; power and reset bits clear = enabled
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cfg_q <= `SMRC_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= PWDATA[`SMRC_CFG_WIDTH-1:0];
        end
    end

    // Level select survives system resets, only power-on clears it
    always_ff @(posedge CLK_SYS or negedge POR_N) begin
        if (!POR_N) begin
            lvl_sel_q <= 1'b0;
        end else if (wr_cfg) begin
            lvl_sel_q <= PWDATA[`SMRC_CFG_LVL_SEL];
        end
    end

    // Comparator needs time after a level change; hold results meanwhile
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            settle_q <= '0;
        end else if (wr_cfg && (PWDATA[`SMRC_CFG_LVL_SEL] != lvl_sel_q)) begin
            settle_q <= SETTLE_W'(SETTLE_CYC);
        end else if (!settled) begin
            settle_q <= settle_q - 1'b1;
        end
    end

    // Low-supply flag with hysteresis
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            flag_q <= 1'b0;
        end else if (active && settled) begin
            if (below_s) begin
                flag_q <= 1'b1;
            end else if (above_s) begin
                flag_q <= 1'b0;
            end
        end
    end

    // Held across the system reset it causes; of the two resets only power-on clears it
    always_ff @(posedge CLK_SYS or negedge POR_N) begin
        if (!POR_N) begin
            trip_q <= 1'b0;
        end else if (trip_set) begin
            trip_q <= 1'b1;
        end else if (!active || (settled && above_s)) begin
            trip_q <= 1'b0;
        end
    end

    // Sticky events; a new event beats a read-clear in the same cycle
    assign evt_hit[`SMRC_EVT_TRIP]    = trip_set && !trip_q;
    assign evt_hit[`SMRC_EVT_LOW]     = low_set;
    assign evt_hit[`SMRC_EVT_RECOVER] = trip_q && !trip_set && active && settled && above_s;

    // Read-clear keeps only what arrives in the same cycle
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            evt_q <= `SMRC_EVT_RESET;
        end else if (rd_evt) begin
            evt_q <= evt_hit;
        end else begin
            evt_q <= evt_q | evt_hit;
        end
    end

    // Mask starts closed so nothing interrupts unless software opts in
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            mask_q <= `SMRC_MASK_RESET;
        end else if (apb_fire && PWRITE && (sel_reg == smrc_pkg::SMRC_REG_MASK)) begin
            mask_q <= PWDATA[`SMRC_EVT_WIDTH-1:0];
        end
    end

    // Level interrupt, one flop behind the sticky events
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & mask_q);
        end
    end

    // No wait state: ready rises for the first access-phase cycle only
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= PSEL && !PENABLE;
        end
    end

    // Unmapped words answer with an error beside ready, never alone
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pslverr_q <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            pslverr_q <= (sel_reg == smrc_pkg::SMRC_REG_NONE);
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // Read data set up at the setup edge so it stands while ready is high;
    // zero otherwise, which keeps stale status off the bus
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            prdata_q <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (sel_reg)
                smrc_pkg::SMRC_REG_CONFIG: prdata_q <= {28'h000_0000, cfg_q[3], cfg_q[2:0]} |
                                                     {28'h000_0000, lvl_sel_q, 3'b000};
                smrc_pkg::SMRC_REG_STATUS: prdata_q <= {24'h00_0000, flag_q, 7'h00};
                smrc_pkg::SMRC_REG_EVENT:  prdata_q <= {29'h0000_0000, evt_q};
                smrc_pkg::SMRC_REG_MASK:   prdata_q <= {29'h0000_0000, mask_q};
                smrc_pkg::SMRC_REG_NONE:   prdata_q <= 32'h0000_0000;
            endcase
        end else begin
            prdata_q <= 32'h0000_0000;
        end
    end

    // Comparator power follows the active decision, one flop late
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= !active;
        end
    end

    // Reset pin is open drain: the level stays low, only the enable moves
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_out_q <= 1'b0;
        end else begin
            rst_out_q <= 1'b0;
        end
    end

    assign PREADY         = pready_q;
    assign PRDATA         = prdata_q;
    assign PSLVERR        = pslverr_q;
    assign IRQ            = irq_q;
    assign CMP_POWER_DOWN = pd_q;
    assign CMP_LEVEL_HIGH = lvl_sel_q;
    assign RESET_REQ      = trip_q;
    assign RST_PIN_OUT    = rst_out_q;
    assign RST_PIN_OE     = trip_q;

endmodule

/* File: verilog/smrc_consts.svh */
`ifndef SMRC_CONSTS_SVH
`define SMRC_CONSTS_SVH

// Byte addresses of the register words
`define SMRC_OFS_CONFIG  16'hFE08
`define SMRC_OFS_STATUS  16'hFE0C
`define SMRC_OFS_EVENT   16'hFE10
`define SMRC_OFS_MASK    16'hFE14

// Configuration word fields
`define SMRC_CFG_PWR_DIS   0
`define SMRC_CFG_RST_DIS   1
`define SMRC_CFG_STOP_EN   2
`define SMRC_CFG_LVL_SEL   3
`define SMRC_CFG_WIDTH     4
`define SMRC_CFG_RESET     4'h0

// Status word: low-supply flag in the top bit
`define SMRC_STAT_FLAG     7
`define SMRC_STAT_RESET    8'h00

// Event and mask fields
`define SMRC_EVT_TRIP      0
`define SMRC_EVT_LOW       1
`define SMRC_EVT_RECOVER   2
`define SMRC_EVT_WIDTH     3
`define SMRC_EVT_RESET     3'h0
`define SMRC_MASK_RESET    3'h0

// Timing
`define SMRC_CLK_PERIOD_NS 10
`define SMRC_SETTLE_NS     30
`define SMRC_SYNC_STAGES   2

`endif

/* File: verilog/smrc_pkg.sv */
package smrc_pkg;

    // Decoded register selected by an APB address
    typedef enum logic [2:0] {
        SMRC_REG_NONE   = 3'b000,
        SMRC_REG_CONFIG = 3'b001,
        SMRC_REG_STATUS = 3'b010,
        SMRC_REG_EVENT  = 3'b011,
        SMRC_REG_MASK   = 3'b100
    } smrc_reg_t;

endpackage

/* File: verif/smrc_cmp_model.sv */
`timescale 1ns/1ps
// Comparator stand-in; supply level in tenths of a volt
module smrc_cmp_model #(
    parameter int LO_F = 27,
    parameter int LO_R = 29,
    parameter int HI_F = 42,
    parameter int HI_R = 44
) (
    input  wire logic       pd,
    input  wire logic       hi,
    input  wire logic [7:0] vdd,
    output logic            below,
    output logic            above
);
    // Selected pair applies; a powered-down comparator gives no result
    always_comb begin
        below = !pd && (vdd < (hi ? HI_F : LO_F));
        above = !pd && (vdd > (hi ? HI_R : LO_R));
    end
endmodule

/* File: verif/smrc_top_assertions.sv */
`timescale 1ns/1ps
`include "smrc_consts.svh"
// Port-level checks on the supply monitor
module smrc_top_assertions #(
    parameter int ADDR_W = 16
) (
    input wire logic              CLK_SYS,
    input wire logic              NRST,
    input wire logic              POR_N,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic              PREADY,
    input wire logic [31:0]       PRDATA,
    input wire logic              PSLVERR,
    input wire logic              CMP_BELOW_FALL,
    input wire logic              CMP_ABOVE_RISE,
    input wire logic              STOP_MODE,
    input wire logic              WAIT_MODE,
    input wire logic              CMP_POWER_DOWN,
    input wire logic              CMP_LEVEL_HIGH,
    input wire logic              RESET_REQ,
    input wire logic              RST_PIN_OUT,
    input wire logic              RST_PIN_OE,
    input wire logic              IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // Bus answers in one access cycle, flags stay mapped
    chk_ready_once: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after setup");
    chk_unmapped_err: assert property (PREADY |-> PSLVERR == !(PADDR inside
        {`SMRC_OFS_CONFIG, `SMRC_OFS_STATUS, `SMRC_OFS_EVENT, `SMRC_OFS_MASK}))
        else $error("slave error does not match address map");
    chk_status_zeros: assert property (PREADY && !PWRITE && PADDR == `SMRC_OFS_STATUS
        |-> PRDATA[31:8] == 0 && PRDATA[6:0] == 0) else $error("status low bits not zero");
    // Pin drive mirrors the request, always pulling low
    chk_pin_follows: assert property (RST_PIN_OE == RESET_REQ && !RST_PIN_OUT)
        else $error("reset pin drive wrong");
    chk_pd_quiet: assert property (CMP_POWER_DOWN && $past(CMP_POWER_DOWN) |-> !$rose(RESET_REQ))
        else $error("request while powered down");
    // Two sync stages: a trip shows three edges after the comparator
    chk_req_rise: assert property (disable iff (!NRST || !POR_N) $rose(RESET_REQ)
        |-> $past(CMP_BELOW_FALL, 3) || $rose(CMP_LEVEL_HIGH)) else $error("request rise without cause");
    chk_req_fall: assert property (disable iff (!NRST || !POR_N) $fell(RESET_REQ)
        |-> $past(CMP_ABOVE_RISE, 3) || CMP_POWER_DOWN || STOP_MODE || $past(STOP_MODE))
        else $error("request dropped before rising level");
    chk_on_after_reset: assert property ($rose(NRST) |-> !CMP_POWER_DOWN)
        else $error("monitor off after reset");
    chk_por_low_level: assert property ($rose(POR_N) |-> !CMP_LEVEL_HIGH)
        else $error("level select not low after power-on");

    cover property ($rose(RESET_REQ));
    cover property (PREADY && PSLVERR);
    cover property ($rose(IRQ));
endmodule

bind smrc_top smrc_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "smrc_consts.svh"
module tb_top;
    logic        clk, nrst, por_n, psel, pen, pwr, stop, waitm;
    logic        pready, pslverr, rerr, pd, lvl, req, pin_o, pin_oe, irq, bf, ar;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  vdd;
    int          num_errors = 0;
    int          n_checks = 0;
    localparam logic [15:0] CFG = `SMRC_OFS_CONFIG;
    localparam logic [15:0] STA = `SMRC_OFS_STATUS;

    smrc_top dut (.CLK_SYS(clk), .NRST(nrst), .POR_N(por_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .CMP_BELOW_FALL(bf), .CMP_ABOVE_RISE(ar), .STOP_MODE(stop), .WAIT_MODE(waitm),
        .CMP_POWER_DOWN(pd), .CMP_LEVEL_HIGH(lvl), .RESET_REQ(req), .RST_PIN_OUT(pin_o),
        .RST_PIN_OE(pin_oe), .IRQ(irq));
    smrc_cmp_model cmp (.pd(pd), .hi(lvl), .vdd(vdd), .below(bf), .above(ar));

    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 9 && pready !== 1'b1; i++)
            @(posedge clk);
        if (pready !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(logic [15:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("read %h", a), e, rdat);
    endtask

    // Two-stage synchroniser latency is fixed, so waits are counted
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic sup(logic [7:0] v, int n);
        @(posedge clk);
        vdd <= v;
        settle(n);
    endtask

    task automatic pulse(logic por);
        @(posedge clk);
        nrst <= 1'b0;
        por_n <= !por;
        @(posedge clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        settle(1);
    endtask

    // Reset, then scenarios in order
    initial begin
        {nrst, por_n, psel, pen, pwr, stop, waitm} = '0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        vdd = 8'd50;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        settle(1);
        chk("level", 1'b0, lvl);
        rd(CFG, 8'h00);
        rd(STA, 8'h00);
        apb(1'b1, STA, 32'hFFFF_FFFF);
        rd(STA, 8'h00);
        chk("mapped error", 1'b0, rerr);
        rd(16'hFE00, 8'h00);
        chk("unmapped error", 1'b1, rerr);
        apb(1'b1, CFG, 8'h02);
        sup(8'd20, 6);
        chk("polled request", 1'b0, req);
        rd(STA, 8'h80);
        chk("masked irq", 1'b0, irq);
        rd(`SMRC_OFS_EVENT, 8'h02);
        sup(8'd30, 6);
        apb(1'b1, `SMRC_OFS_MASK, 8'h01);
        apb(1'b1, CFG, 8'h00);
        sup(8'd20, 2);
        chk("early request", 1'b0, req);
        settle(1);
        chk("request", 1'b1, req);
        chk("pin", 2'b10, {pin_oe, pin_o});
        settle(1);
        chk("irq", 1'b1, irq);
        sup(8'd28, 6);
        chk("hysteresis", 1'b1, req);
        rd(STA, 8'h80);
        sup(8'd30, 6);
        chk("release", 1'b0, req);
        rd(STA, 8'h00);
        rd(`SMRC_OFS_EVENT, 8'h07);
        rd(`SMRC_OFS_EVENT, 8'h00);
        settle(2);
        chk("irq cleared", 1'b0, irq);
        apb(1'b1, CFG, 8'h01);
        sup(8'd20, 6);
        chk("power down", 2'b10, {pd, req});
        rd(STA, 8'h00);
        sup(8'd30, 6);
        apb(1'b1, CFG, 8'h00);
        stop <= 1'b1;
        sup(8'd20, 6);
        chk("stop off", 1'b0, req);
        apb(1'b1, CFG, 8'h04);
        settle(6);
        chk("stop on", 1'b1, req);
        stop <= 1'b0;
        waitm <= 1'b1;
        sup(8'd30, 6);
        sup(8'd20, 6);
        chk("wait on", 1'b1, req);
        waitm <= 1'b0;
        sup(8'd35, 6);
        apb(1'b1, CFG, 8'h08);
        settle(0);
        chk("raise level", 2'b11, {lvl, req});
        sup(8'd50, 8);
        chk("level release", 1'b0, req);
        apb(1'b1, CFG, 8'h0A);
        sup(8'd40, 6);
        rd(STA, 8'h80);
        sup(8'd43, 6);
        rd(STA, 8'h80);
        pulse(1'b0);
        chk("level kept", 1'b1, lvl);
        rd(STA, 8'h00);
        pulse(1'b1);
        chk("level low", 1'b0, lvl);
        complete_run();
    end
endmodule
